// [rtl/pms_pkg.sv]
// What this block does
// RULE1: set warning flag when supply is below warning trip, including right after reset.
// RULE2: warning flag reads 1 while warning present and stays set until acknowledged.
// RULE3: writing 1 to bit 6 clears warning flag only if no warning present.
// RULE4: bit 5 picks detect trip: 0 low level, 1 high level.
// RULE5: bit 4 picks warning trip: 0 low threshold, 1 high threshold.
// RULE6: power-on reset clears all bits; other resets keep both trip selects.
// RULE7: set partial power-down flag in bit 3 on exit from partial stop.
// RULE8: writing 1 to bit 2 clears the partial power-down flag.
// RULE9: write-once bit 1 gates entry to both power-down stops.
// RULE10: write-once bit 0 picks full (0) or partial (1) power-down stop.
// RULE11: write-once bits take only the first write after reset.
// RULE12: acknowledge bits read as 0; writing 0 to them does nothing.
// RULE13: a flag set in the same cycle as its acknowledge wins over the clear.
//
// Purpose: constants and types for the power management status/control block
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes: register offsets are byte addresses
package pms_pkg;

    // register byte offsets
    localparam logic [7:0] PMS_OFF_CTRL = 8'h00;
    localparam logic [7:0] PMS_OFF_STAT = 8'h04;
    localparam int PMS_ADDR_W = 8;

    // control register field positions
    localparam int PMS_B_WARN_FLAG = 7;
    localparam int PMS_B_WARN_ACK = 6;
    localparam int PMS_B_DET_TRIP = 5;
    localparam int PMS_B_WARN_TRIP = 4;
    localparam int PMS_B_PPD_FLAG = 3;
    localparam int PMS_B_PPD_ACK = 2;
    localparam int PMS_B_PD_EN = 1;
    localparam int PMS_B_PD_KIND = 0;

    // status register field positions
    localparam int PMS_S_WARN_NOW = 0;
    localparam int PMS_S_ONCE_LOCK = 1;
    localparam int PMS_S_LAST_PART = 2;
    localparam int PMS_S_LAST_FULL = 3;

    // reset value of the control register
    localparam logic [7:0] PMS_CTRL_RST = 8'h00;

    // ahb transfer codes
    localparam logic [1:0] PMS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PMS_HTRANS_SEQ = 2'h3;
    localparam logic PMS_HRESP_OKAY = 1'h0;

    // stored control fields
    typedef struct packed {
        logic supply_warn_flag;
        logic detect_trip_select;
        logic warn_trip_select;
        logic partial_pd_flag;
        logic powerdown_enable;
        logic powerdown_kind_select;
    } pms_ctrl_s;

    // captured address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [PMS_ADDR_W-1:0] addr;
    } pms_aphase_s;

    // bus data phase state
    typedef enum logic [1:0] {
        PMS_DP_IDLE,
        PMS_DP_WRITE,
        PMS_DP_READ_WAIT,
        PMS_DP_READ_DONE
    } pms_dphase_e;

endpackage

// [rtl/pms_power_ctrl.sv]
// Purpose: power management status and control register with stop gating
// Assumes: single clock, synchronous reset, ahb-lite slave, inputs synchronous
// Notes: por_i qualifies srst_i to tell power-on reset from other resets
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pms_power_ctrl (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic por_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // supply monitor and stop sequencing
    input wire logic undervoltage_warning_i,
    input wire logic partial_powerdown_exit_i,
    input wire logic stop_req_i,
    // control outputs
    output logic detect_trip_select_o,
    output logic warn_trip_select_o,
    output logic powerdown_enable_o,
    output logic powerdown_kind_select_o,
    output logic supply_warn_flag_o,
    output logic partial_pd_flag_o,
    output logic full_powerdown_stop_o,
    output logic partial_powerdown_stop_o,
    output logic plain_stop_o
);

    pms_pkg::pms_ctrl_s ctrl_r;
    pms_pkg::pms_aphase_s aph_r;
    pms_pkg::pms_dphase_e dph_r;
    logic once_lock_r;
    logic last_part_r;
    logic last_full_r;
    logic [31:0] hrdata_r;
    logic addr_take;
    logic wr_ctrl;
    logic [7:0] wbyte;

    // gather the readable word of a register
    function automatic logic [31:0] read_word(
        input logic [pms_pkg::PMS_ADDR_W-1:0] addr,
        input pms_pkg::pms_ctrl_s c,
        input logic warn_now,
        input logic lock,
        input logic part,
        input logic full
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        if (addr == pms_pkg::PMS_OFF_CTRL) begin
            w[pms_pkg::PMS_B_WARN_FLAG] = c.supply_warn_flag;
            w[pms_pkg::PMS_B_DET_TRIP] = c.detect_trip_select;
            w[pms_pkg::PMS_B_WARN_TRIP] = c.warn_trip_select;
            w[pms_pkg::PMS_B_PPD_FLAG] = c.partial_pd_flag;
            w[pms_pkg::PMS_B_PD_EN] = c.powerdown_enable;
            w[pms_pkg::PMS_B_PD_KIND] = c.powerdown_kind_select;
        end else if (addr == pms_pkg::PMS_OFF_STAT) begin
            w[pms_pkg::PMS_S_WARN_NOW] = warn_now;
            w[pms_pkg::PMS_S_ONCE_LOCK] = lock;
            w[pms_pkg::PMS_S_LAST_PART] = part;
            w[pms_pkg::PMS_S_LAST_FULL] = full;
        end
        return w;
    endfunction

    // a transfer is taken only when selected, active and the bus is ready
    assign addr_take = hsel_i && hready_i && (htrans_i == pms_pkg::PMS_HTRANS_NONSEQ ||
        htrans_i == pms_pkg::PMS_HTRANS_SEQ);

    // address phase capture
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            aph_r <= '0;
        end else if (hready_i) begin
            aph_r.valid <= addr_take;
            aph_r.write <= hwrite_i;
            aph_r.addr <= haddr_i[pms_pkg::PMS_ADDR_W-1:0];
        end
    end

    // data phase sequencing; reads take one wait so the last write is seen
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dph_r <= pms_pkg::PMS_DP_IDLE;
        end else begin
            case (dph_r)
                pms_pkg::PMS_DP_READ_WAIT: begin
                    dph_r <= pms_pkg::PMS_DP_READ_DONE;
                end
                default: begin
                    if (addr_take && hwrite_i) begin
                        dph_r <= pms_pkg::PMS_DP_WRITE;
                    end else if (addr_take) begin
                        dph_r <= pms_pkg::PMS_DP_READ_WAIT;
                    end else begin
                        dph_r <= pms_pkg::PMS_DP_IDLE;
                    end
                end
            endcase
        end
    end

    // bus answers
    assign hreadyout_o = (dph_r != pms_pkg::PMS_DP_READ_WAIT);
    assign hresp_o = pms_pkg::PMS_HRESP_OKAY;
    assign hrdata_o = hrdata_r;

    // read data latched in the wait cycle; unmapped offsets read zero
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hrdata_r <= 32'h0000_0000;
        end else if (dph_r == pms_pkg::PMS_DP_READ_WAIT) begin
            hrdata_r <= read_word(aph_r.addr, ctrl_r, undervoltage_warning_i,
                once_lock_r, last_part_r, last_full_r); // [RULE12]
        end
    end

    // write strobe to the control register; hsize is ignored, whole word only
    assign wr_ctrl = (dph_r == pms_pkg::PMS_DP_WRITE) &&
        (aph_r.addr == pms_pkg::PMS_OFF_CTRL);
    assign wbyte = hwdata_i[7:0];

    // sticky warning flag: the live condition outranks the acknowledge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_r.supply_warn_flag <= 1'h0; // [RULE6]
        end else if (undervoltage_warning_i) begin
            ctrl_r.supply_warn_flag <= 1'h1; // [RULE1] [RULE2] [RULE13]
        end else if (wr_ctrl && wbyte[pms_pkg::PMS_B_WARN_ACK]) begin
            ctrl_r.supply_warn_flag <= 1'h0; // [RULE3] [RULE12]
        end
    end

    // trip selects survive every reset except power-on
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            if (por_i) begin
                ctrl_r.detect_trip_select <= 1'h0; // [RULE6]
                ctrl_r.warn_trip_select <= 1'h0; // [RULE6]
            end
        end else if (wr_ctrl) begin
            ctrl_r.detect_trip_select <= wbyte[pms_pkg::PMS_B_DET_TRIP]; // [RULE4]
            ctrl_r.warn_trip_select <= wbyte[pms_pkg::PMS_B_WARN_TRIP]; // [RULE5]
        end
    end

    // partial power-down flag: exit event outranks the acknowledge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_r.partial_pd_flag <= 1'h0; // [RULE6]
        end else if (partial_powerdown_exit_i) begin
            ctrl_r.partial_pd_flag <= 1'h1; // [RULE7] [RULE13]
        end else if (wr_ctrl && wbyte[pms_pkg::PMS_B_PPD_ACK]) begin
            ctrl_r.partial_pd_flag <= 1'h0; // [RULE8] [RULE12]
        end
    end

    // write-once power-down bits; one lock covers both since they share a write
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_r.powerdown_enable <= 1'h0; // [RULE6]
            ctrl_r.powerdown_kind_select <= 1'h0;
            once_lock_r <= 1'h0;
        end else if (wr_ctrl && !once_lock_r) begin
            ctrl_r.powerdown_enable <= wbyte[pms_pkg::PMS_B_PD_EN]; // [RULE9]
            ctrl_r.powerdown_kind_select <= wbyte[pms_pkg::PMS_B_PD_KIND]; // [RULE10]
            once_lock_r <= 1'h1; // [RULE11]
        end
    end

    // stop request steering: request registered for one cycle and sent to the chosen stop kind
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            full_powerdown_stop_o <= 1'h0;
            partial_powerdown_stop_o <= 1'h0;
            plain_stop_o <= 1'h0;
        end else begin
            full_powerdown_stop_o <= stop_req_i && ctrl_r.powerdown_enable &&
                !ctrl_r.powerdown_kind_select; // [RULE9] [RULE10]
            partial_powerdown_stop_o <= stop_req_i && ctrl_r.powerdown_enable &&
                ctrl_r.powerdown_kind_select; // [RULE9] [RULE10]
            plain_stop_o <= stop_req_i && !ctrl_r.powerdown_enable; // [RULE9]
        end
    end

    // remember which kind of power-down stop was last entered
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            last_part_r <= 1'h0;
            last_full_r <= 1'h0;
        end else if (stop_req_i && ctrl_r.powerdown_enable) begin
            last_part_r <= ctrl_r.powerdown_kind_select;
            last_full_r <= !ctrl_r.powerdown_kind_select;
        end
    end

    // register fields straight to the analog and sequencer side
    assign detect_trip_select_o = ctrl_r.detect_trip_select;
    assign warn_trip_select_o = ctrl_r.warn_trip_select;
    assign powerdown_enable_o = ctrl_r.powerdown_enable;
    assign powerdown_kind_select_o = ctrl_r.powerdown_kind_select;
    assign supply_warn_flag_o = ctrl_r.supply_warn_flag;
    assign partial_pd_flag_o = ctrl_r.partial_pd_flag;

endmodule
`default_nettype wire

// [verification/pms_checker.sv]
// Purpose: concurrent checks on the power management register block ports
// Assumes: one clock, srst_i synchronous, bus writes complete with no wait state
// Notes: helper flags follow the control register data phase only
`timescale 1ns/1ns
`default_nettype none
module pms_checker (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic por_i,
    // bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    // monitor and controls
    input wire logic undervoltage_warning_i,
    input wire logic partial_powerdown_exit_i,
    input wire logic stop_req_i,
    input wire logic detect_trip_select_o,
    input wire logic warn_trip_select_o,
    input wire logic powerdown_enable_o,
    input wire logic powerdown_kind_select_o,
    input wire logic supply_warn_flag_o,
    input wire logic partial_pd_flag_o,
    input wire logic full_powerdown_stop_o,
    input wire logic partial_powerdown_stop_o,
    input wire logic plain_stop_o
);
    logic take;
    logic wr_dp_r;
    logic rd_dp_r;
    logic lock_r;
    // control register address phase accepted
    assign take = hsel_i && hready_i && htrans_i[1] && (haddr_i[7:0] == pms_pkg::PMS_OFF_CTRL);
    // data phase flags advance only on ready, since reads stall one cycle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_dp_r <= 1'b0;
            rd_dp_r <= 1'b0;
        end else if (hreadyout_o) begin
            wr_dp_r <= take && hwrite_i;
            rd_dp_r <= take && !hwrite_i;
        end
    end
    // any finished control write locks the write-once pair
    always_ff @(posedge mclk_i) begin
        lock_r <= srst_i ? 1'b0 : (lock_r || wr_dp_r);
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_warn_set; undervoltage_warning_i |=> supply_warn_flag_o; endproperty
    a_warn_set: assert property (p_warn_set) else $error("warn flag missed");
    property p_sticky; supply_warn_flag_o && !(wr_dp_r && hwdata_i[6]) |=> supply_warn_flag_o; endproperty
    a_sticky: assert property (p_sticky) else $error("warn flag dropped");
    property p_ack; wr_dp_r && hwdata_i[6] && !undervoltage_warning_i |=> !supply_warn_flag_o; endproperty
    a_ack: assert property (p_ack) else $error("warn ack failed");
    property p_trip; wr_dp_r |=> {detect_trip_select_o, warn_trip_select_o} == $past(hwdata_i[5:4]); endproperty
    a_trip: assert property (p_trip) else $error("trip select wrong");
    property p_por; disable iff (1'b0) srst_i && por_i |=> !(detect_trip_select_o || warn_trip_select_o || powerdown_enable_o || powerdown_kind_select_o || supply_warn_flag_o || partial_pd_flag_o); endproperty
    a_por: assert property (p_por) else $error("power-on clear wrong");
    property p_keep; disable iff (1'b0) srst_i && !por_i |=> $stable(detect_trip_select_o) && $stable(warn_trip_select_o) && !powerdown_enable_o; endproperty
    a_keep: assert property (p_keep) else $error("warm reset wrong");
    property p_ppd; partial_powerdown_exit_i |=> partial_pd_flag_o; endproperty
    a_ppd: assert property (p_ppd) else $error("ppd flag missed");
    property p_ppd_ack; wr_dp_r && hwdata_i[2] && !partial_powerdown_exit_i |=> !partial_pd_flag_o; endproperty
    a_ppd_ack: assert property (p_ppd_ack) else $error("ppd ack failed");
    property p_stop; stop_req_i |=> {full_powerdown_stop_o, partial_powerdown_stop_o, plain_stop_o} == {$past(powerdown_enable_o) && !$past(powerdown_kind_select_o), $past(powerdown_enable_o) && $past(powerdown_kind_select_o), !$past(powerdown_enable_o)}; endproperty
    a_stop: assert property (p_stop) else $error("stop steering wrong");
    property p_once; lock_r && wr_dp_r |=> $stable(powerdown_enable_o) && $stable(powerdown_kind_select_o); endproperty
    a_once: assert property (p_once) else $error("write-once changed");
    property p_ack_rd; rd_dp_r && hreadyout_o |-> !hrdata_o[6] && !hrdata_o[2]; endproperty
    a_ack_rd: assert property (p_ack_rd) else $error("ack bit read as 1");
endmodule
bind pms_power_ctrl pms_checker u_chk (.mclk_i, .srst_i, .por_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .undervoltage_warning_i,
    .partial_powerdown_exit_i, .stop_req_i, .detect_trip_select_o, .warn_trip_select_o,
    .powerdown_enable_o, .powerdown_kind_select_o, .supply_warn_flag_o, .partial_pd_flag_o,
    .full_powerdown_stop_o, .partial_powerdown_stop_o, .plain_stop_o);
`default_nettype wire

// [verification/pms_power_ctrl_tb.sv]
// Purpose: self-checking bench for the power management register block
// Assumes: bench is the only bus master, hready fed back from hreadyout
// Notes: write-once pair locks on the first control write, rows run first
`timescale 1ns/1ns
`default_nettype none
module pms_power_ctrl_tb;
    logic mclk_i, srst_i, por_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic undervoltage_warning_i, partial_powerdown_exit_i, stop_req_i;
    logic [1:0] htrans_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rdat;
    logic detect_trip_select_o, warn_trip_select_o, powerdown_enable_o, powerdown_kind_select_o;
    logic supply_warn_flag_o, partial_pd_flag_o;
    logic full_powerdown_stop_o, partial_powerdown_stop_o, plain_stop_o;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    // write value beside expected readback; the lock keeps bits 1:0 after row 0
    localparam logic [15:0] ROWS [4] = '{16'h3333, 16'h0003, 16'h2023, 16'h4403};
    pms_power_ctrl dut (.mclk_i, .srst_i, .por_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o,
        .undervoltage_warning_i, .partial_powerdown_exit_i, .stop_req_i, .detect_trip_select_o,
        .warn_trip_select_o, .powerdown_enable_o, .powerdown_kind_select_o, .supply_warn_flag_o,
        .partial_pd_flag_o, .full_powerdown_stop_o, .partial_powerdown_stop_o, .plain_stop_o);
    task end_of_test;
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ready is looked at before the edge so the edge itself never races
    task wait_rdy(output logic [31:0] d);
        do @(negedge mclk_i); while (hreadyout_o !== 1'b1);
        d = hrdata_o;
        @(posedge mclk_i);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        haddr_i <= {24'h0, a};
        hwrite_i <= 1'b1;
        htrans_i <= pms_pkg::PMS_HTRANS_NONSEQ;
        wait_rdy(rdat);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        wait_rdy(rdat);
    endtask
    task rd_cmp(input logic [7:0] a, input logic [7:0] e);
        haddr_i <= {24'h0, a};
        hwrite_i <= 1'b0;
        htrans_i <= pms_pkg::PMS_HTRANS_NONSEQ;
        wait_rdy(rdat);
        htrans_i <= 2'h0;
        wait_rdy(rdat);
        cmp(rdat, {24'h0, e});
    endtask
    // stop steering pulses appear one cycle after the request
    task stp(input logic [2:0] e);
        stop_req_i <= 1'b1;
        @(posedge mclk_i);
        stop_req_i <= 1'b0;
        #1;
        cmp({29'h0, full_powerdown_stop_o, partial_powerdown_stop_o, plain_stop_o}, {29'h0, e});
        @(posedge mclk_i);
    endtask
    task rst(input logic p);
        srst_i <= 1'b1;
        por_i <= p;
        @(posedge mclk_i);
        srst_i <= 1'b0;
        por_i <= 1'b0;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    // hang guard, the whole run needs about a hundred cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        {srst_i, por_i, hsel_i, hwrite_i} = 4'hF;
        {undervoltage_warning_i, partial_powerdown_exit_i, stop_req_i} = 3'h0;
        htrans_i = 2'h0;
        haddr_i = 32'h0;
        hwdata_i = 32'h0;
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b0;
        por_i <= 1'b0;
        rd_cmp(8'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, ROWS[i][15:8]);
            rd_cmp(8'h00, ROWS[i][7:0]);
        end
        undervoltage_warning_i <= 1'b1;
        @(posedge mclk_i);
        undervoltage_warning_i <= 1'b0;
        rd_cmp(8'h00, 8'h83);
        undervoltage_warning_i <= 1'b1;
        wr(8'h00, 8'h40);
        rd_cmp(8'h00, 8'h83);
        undervoltage_warning_i <= 1'b0;
        wr(8'h00, 8'h40);
        rd_cmp(8'h00, 8'h03);
        partial_powerdown_exit_i <= 1'b1;
        @(posedge mclk_i);
        partial_powerdown_exit_i <= 1'b0;
        rd_cmp(8'h00, 8'h0B);
        wr(8'h00, 8'h04);
        rd_cmp(8'h00, 8'h03);
        partial_powerdown_exit_i <= 1'b1;
        wr(8'h00, 8'h04);
        partial_powerdown_exit_i <= 1'b0;
        rd_cmp(8'h00, 8'h0B);
        stp(3'b010);
        wr(8'h00, 8'h30);
        undervoltage_warning_i <= 1'b1;
        rst(1'b0);
        rd_cmp(8'h00, 8'hB0);
        undervoltage_warning_i <= 1'b0;
        rst(1'b1);
        rd_cmp(8'h00, 8'h00);
        stp(3'b001);
        wr(8'h00, 8'h02);
        stp(3'b100);
        rd_cmp(8'h08, 8'h00);
        rd_cmp(8'h04, 8'h0A);
        cmp({31'h0, hresp_o}, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
